// [core/ebwbc_pkg.sv]
/*
  Constants for the external-bus wait-state and bank-switch control block:
  register offsets, field positions, reset values and the one-hot states.
  Assumes a single 50 MHz machine clock; all timing is in machine cycles.
*/
package ebwbc_pkg;
  localparam logic [15:0] WAIT_BASE_OFS = 16'h0028;
  localparam logic [15:0] BANK_CTRL_OFS = 16'h0029;
  localparam logic [15:0] WAIT_CTRL_OFS = 16'h002B;
  localparam logic [15:0] WAIT_BASE_RST = 16'h7FFF;
  localparam logic [15:0] BANK_CTRL_RST = 16'hF000;
  localparam logic [15:0] WAIT_CTRL_RST = 16'h0000;
  localparam logic [15:0] WAIT_CTRL_WMASK = 16'h0001;
  localparam logic [15:0] BANK_CTRL_WMASK = 16'hF006;
  localparam int XPA_BIT = 15;
  localparam int IO_LSB = 12;
  localparam int DHI_LSB = 9;
  localparam int DLO_LSB = 6;
  localparam int PHI_LSB = 3;
  localparam int PLO_LSB = 0;
  localparam int MULT_BIT = 0;
  localparam int SEQ_BIT = 15;
  localparam int DIV_MSB = 14;
  localparam int DIV_LSB = 13;
  localparam int ACK_OFF_BIT = 12;
  localparam int HOST_KEEP_BIT = 2;
  localparam int DATA_KEEP_BIT = 1;
  localparam int BANK_BIT = 15;
  localparam int XBANK_BIT = 22;
  localparam int PAGE_MSB = 22;
  localparam int PAGE_LSB = 16;
  localparam logic [1:0] SPACE_PROG = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_STROBE = 5'h04,
    ST_TRAIL = 5'h08,
    ST_DONE = 5'h10
  } ebwbc_state_t;
endpackage

// [core/ebwbc_top.sv]
/*
  External-bus timing control: wait-state generator with multiplier,
  bank-switch idle cycles, divided clock output, intack suppression and
  bus keeper enables. The core reaches the three control registers over
  its memory-mapped register port and asks for external accesses with a
  one-cycle request; memories see the strobe and the held address.
*/
`timescale 1ns/1ps
// Overview of operation
// - base wait count 0-7 per five ranges; seven waits everywhere after reset
// - wait control bits 15-1 reset to zero and ignore writes
// - multiplier clear: base wait counts used unchanged
// - multiplier set: wait counts doubled, fourteen at most
// - one extra divided-clock cycle on program or data read crossing a 32K bank
// - consecutive bit clear: extra cycles only on bank, space or program page change
// - consecutive bit set: each program or data read has start, read and trailing cycle
// - divided clock runs at machine clock over divide field plus one; field zero holds it high
// - intack off bit set at reset suppresses the intack output
// - host keeper bit resets zero; keeper on if bit or wide select
// - data keeper bit resets zero and enables the data bus keeper
// - non-consecutive: bank msb mismatch withholds strobe one divided cycle
// - each program or data read stores its top address bit
// - non-consecutive reads from the same bank, space and program page get no extra cycle
// - extra cycle on bank change, space change, or program page change
// - address keeper needs wide select and host bit; host keeper needs either one
module ebwbc_top (
  input wire logic SYS_CLK, // machine clock
  input wire logic ARST_N, // async reset, low active
  input wire logic [15:0] MMR_ADDR, // register address
  input wire logic [15:0] MMR_WDATA, // register write data
  input wire logic MMR_WE, // register write strobe
  input wire logic MMR_RE, // register read strobe
  output logic [15:0] MMR_RDATA, // register read data
  input wire logic ACC_REQ, // external access request pulse
  input wire logic ACC_READ, // access is a read
  input wire logic [1:0] ACC_SPACE, // program, data or io
  input wire logic [22:0] ACC_ADDR, // access address
  output logic ACC_DONE, // access finished pulse
  output logic ACC_BUSY, // access in progress
  output logic [22:0] EXT_ADDR, // external address bus
  output logic MEM_STROBE_N, // memory strobe, low active
  output logic DIV_CLK_OUT, // divided clock output
  input wire logic INTACK_REQ, // core acknowledge pulse
  output logic INTACK_OUT_N, // acknowledge output, low active
  input wire logic WIDE_HOST_SEL, // wide host port select pin
  output logic DATA_KEEP_EN, // data bus keeper enable
  output logic ADDR_KEEP_EN, // address bus keeper enable
  output logic HOST_KEEP_EN // host data keeper enable
);
  logic rst_s1_reg, rst_n;
  logic sel_s1_reg, sel_s2_reg;
  logic [15:0] wait_base_reg, bank_ctrl_reg, wait_ctrl_reg;
  ebwbc_pkg::ebwbc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] div_cnt_reg;
  logic read_reg, last_msb_reg, last_valid_reg;
  logic [1:0] space_reg, last_space_reg;
  logic [6:0] last_page_reg;
  logic [3:0] wait_reg;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end else begin
      sel_s1_reg <= WIDE_HOST_SEL;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // register decode
  wire hit_base = MMR_ADDR == ebwbc_pkg::WAIT_BASE_OFS;
  wire hit_bank = MMR_ADDR == ebwbc_pkg::BANK_CTRL_OFS;
  wire hit_wctl = MMR_ADDR == ebwbc_pkg::WAIT_CTRL_OFS;
  wire [15:0] bank_wm = ebwbc_pkg::BANK_CTRL_WMASK;
  wire [15:0] wctl_wm = ebwbc_pkg::WAIT_CTRL_WMASK;
  wire [15:0] bank_new = (bank_ctrl_reg & ~bank_wm) | (MMR_WDATA & bank_wm);
  wire [15:0] wctl_new = (wait_ctrl_reg & ~wctl_wm) | (MMR_WDATA & wctl_wm);
  wire [15:0] rd_mux = hit_base ? wait_base_reg :
                       hit_bank ? bank_ctrl_reg :
                       hit_wctl ? wait_ctrl_reg : 16'h0000;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wait_base_reg <= ebwbc_pkg::WAIT_BASE_RST;
      bank_ctrl_reg <= ebwbc_pkg::BANK_CTRL_RST;
      wait_ctrl_reg <= ebwbc_pkg::WAIT_CTRL_RST;
      MMR_RDATA <= 16'h0000;
    end else begin
      if (MMR_WE && hit_base) wait_base_reg <= MMR_WDATA;
      if (MMR_WE && hit_bank) bank_ctrl_reg <= bank_new;
      if (MMR_WE && hit_wctl) wait_ctrl_reg <= wctl_new;
      if (MMR_RE) MMR_RDATA <= rd_mux;
    end
  end

  wire seq_mode = bank_ctrl_reg[ebwbc_pkg::SEQ_BIT];
  wire [1:0] div_fct = bank_ctrl_reg[ebwbc_pkg::DIV_MSB:ebwbc_pkg::DIV_LSB];
  wire mult = wait_ctrl_reg[ebwbc_pkg::MULT_BIT];
  wire xpa = wait_base_reg[ebwbc_pkg::XPA_BIT];

  // base wait count for the requested range
  wire is_prog = ACC_SPACE == ebwbc_pkg::SPACE_PROG;
  wire is_data = ACC_SPACE == ebwbc_pkg::SPACE_DATA;
  wire is_mem = is_prog || is_data;
  wire prog_hi = xpa ? ACC_ADDR[ebwbc_pkg::XBANK_BIT] : ACC_ADDR[ebwbc_pkg::BANK_BIT];
  wire data_hi = ACC_ADDR[ebwbc_pkg::BANK_BIT];
  wire [2:0] base_sel = is_prog ? (prog_hi ? wait_base_reg[ebwbc_pkg::PHI_LSB +: 3] :
                                             wait_base_reg[ebwbc_pkg::PLO_LSB +: 3]) :
                        is_data ? (data_hi ? wait_base_reg[ebwbc_pkg::DHI_LSB +: 3] :
                                             wait_base_reg[ebwbc_pkg::DLO_LSB +: 3]) :
                        wait_base_reg[ebwbc_pkg::IO_LSB +: 3];
  wire [3:0] wait_sel = mult ? {base_sel, 1'b0} : {1'b0, base_sel};

  // bank-switch decision
  wire req_msb = ACC_ADDR[ebwbc_pkg::BANK_BIT];
  wire [6:0] req_page = ACC_ADDR[ebwbc_pkg::PAGE_MSB:ebwbc_pkg::PAGE_LSB];
  wire bank_chg = req_msb != last_msb_reg;
  wire space_chg = ACC_SPACE != last_space_reg;
  wire page_chg = is_prog && (req_page != last_page_reg);
  wire switch_hit = last_valid_reg && (bank_chg || space_chg || page_chg);
  wire need_start = ACC_READ && is_mem &&
                    (seq_mode || switch_hit);
  wire need_trail = read_reg && seq_mode &&
                    (space_reg != ebwbc_pkg::SPACE_IO);
  wire cnt_zero = cnt_reg == 4'h0;
  wire [3:0] idle_len = {2'b00, div_fct}; // one divided-clock cycle

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ebwbc_pkg::ST_IDLE: begin
        if (ACC_REQ && need_start) begin
          state_next = ebwbc_pkg::ST_START;
          cnt_next = idle_len;
        end else if (ACC_REQ) begin
          state_next = ebwbc_pkg::ST_STROBE;
          cnt_next = wait_sel;
        end
      end
      ebwbc_pkg::ST_START: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_zero) begin
          state_next = ebwbc_pkg::ST_STROBE;
          cnt_next = wait_reg;
        end
      end
      ebwbc_pkg::ST_STROBE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_zero && need_trail) begin
          state_next = ebwbc_pkg::ST_TRAIL;
          cnt_next = idle_len;
        end else if (cnt_zero) begin
          state_next = ebwbc_pkg::ST_DONE;
        end
      end
      ebwbc_pkg::ST_TRAIL: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_zero) state_next = ebwbc_pkg::ST_DONE;
      end
      ebwbc_pkg::ST_DONE: begin
        state_next = ebwbc_pkg::ST_IDLE;
      end
      default: begin
        state_next = ebwbc_pkg::ST_IDLE;
        cnt_next = 4'h0;
      end
    endcase
  end

  wire take = (state_reg == ebwbc_pkg::ST_IDLE) && ACC_REQ;
  wire mem_done = (state_reg == ebwbc_pkg::ST_DONE) && read_reg &&
                  (space_reg != ebwbc_pkg::SPACE_IO);

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ebwbc_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      wait_reg <= 4'h0;
      read_reg <= 1'b0;
      space_reg <= ebwbc_pkg::SPACE_PROG;
      EXT_ADDR <= 23'h000000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (take) begin
        wait_reg <= wait_sel;
        read_reg <= ACC_READ;
        space_reg <= ACC_SPACE;
        EXT_ADDR <= ACC_ADDR;
      end
    end
  end

  // last program/data read history
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      last_msb_reg <= 1'b0;
      last_space_reg <= ebwbc_pkg::SPACE_PROG;
      last_page_reg <= 7'h00;
      last_valid_reg <= 1'b0;
    end else if (mem_done) begin
      last_msb_reg <= EXT_ADDR[ebwbc_pkg::BANK_BIT];
      last_space_reg <= space_reg;
      last_page_reg <= EXT_ADDR[ebwbc_pkg::PAGE_MSB:ebwbc_pkg::PAGE_LSB];
      last_valid_reg <= 1'b1;
    end
  end

  // registered outputs
  wire div_wrap = div_cnt_reg >= div_fct;
  wire [1:0] div_cnt_next = div_wrap ? 2'h0 : div_cnt_reg + 2'h1;
  wire div_clk_next = div_cnt_next <= {1'b0, div_fct[1]};
  wire host_keep = bank_ctrl_reg[ebwbc_pkg::HOST_KEEP_BIT];

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 2'h0;
      DIV_CLK_OUT <= 1'b1;
      MEM_STROBE_N <= 1'b1;
      ACC_DONE <= 1'b0;
      ACC_BUSY <= 1'b0;
      INTACK_OUT_N <= 1'b1;
      DATA_KEEP_EN <= 1'b0;
      ADDR_KEEP_EN <= 1'b0;
      HOST_KEEP_EN <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      DIV_CLK_OUT <= div_clk_next;
      MEM_STROBE_N <= state_next != ebwbc_pkg::ST_STROBE;
      ACC_DONE <= state_next == ebwbc_pkg::ST_DONE;
      ACC_BUSY <= state_next != ebwbc_pkg::ST_IDLE;
      INTACK_OUT_N <= bank_ctrl_reg[ebwbc_pkg::ACK_OFF_BIT] | ~INTACK_REQ;
      DATA_KEEP_EN <= bank_ctrl_reg[ebwbc_pkg::DATA_KEEP_BIT];
      ADDR_KEEP_EN <= sel_s2_reg & host_keep;
      HOST_KEEP_EN <= sel_s2_reg | host_keep;
    end
  end

  // checking helpers
  logic [4:0] low_cnt_reg;
  logic [2:0] clk_per_reg;
  logic per_ok_reg;

  // period count trusted only from the first rise after a divide change
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      per_ok_reg <= 1'b0;
    end else if (div_fct != $past(div_fct)) begin
      per_ok_reg <= 1'b0;
    end else if (DIV_CLK_OUT && !$past(DIV_CLK_OUT)) begin
      per_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 5'h00;
      clk_per_reg <= 3'h0;
    end else begin
      low_cnt_reg <= MEM_STROBE_N ? 5'h00 : low_cnt_reg + 5'h01;
      clk_per_reg <= (DIV_CLK_OUT && !$past(DIV_CLK_OUT)) ? 3'h1 : clk_per_reg + 3'h1;
    end
  end

  // register fields
  wctl_rsvd_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    wait_ctrl_reg[15:1] == 15'h0000) else $error("wait control reserved bits set");
  bank_rsvd_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    bank_ctrl_reg[11:3] == 9'h000 && !bank_ctrl_reg[0]) else $error("bank reserved bits set");
  wait_scale_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    take |-> wait_sel == (mult ? 4'(base_sel) * 4'h2 : 4'(base_sel)))
    else $error("wait count not scaled by multiplier");
  strobe_len_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(MEM_STROBE_N) |-> low_cnt_reg == 5'(wait_reg) + 5'h01)
    else $error("strobe width differs from wait count");
  wait_max_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    take |-> wait_sel <= 4'hE) else $error("wait count above fourteen");

  // access sequencing
  seq_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    take && seq_mode && ACC_READ && is_mem |=> state_reg == ebwbc_pkg::ST_START)
    else $error("consecutive read lacks starting cycle");
  same_bank_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    take && !seq_mode && !switch_hit |=> state_reg == ebwbc_pkg::ST_STROBE)
    else $error("extra cycle on same bank read");
  bank_gap_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    take && !seq_mode && ACC_READ && is_mem && switch_hit && $stable(div_fct)
    |=> MEM_STROBE_N [*1] ##0 (state_reg == ebwbc_pkg::ST_START))
    else $error("strobe not withheld on bank change");
  msb_store_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    mem_done |=> last_msb_reg == $past(EXT_ADDR[ebwbc_pkg::BANK_BIT]))
    else $error("bank bit not stored");
  history_once_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    mem_done |=> !mem_done) else $error("history loaded twice for one read");
  io_no_start_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    take && ACC_SPACE == ebwbc_pkg::SPACE_IO |=> state_reg != ebwbc_pkg::ST_START)
    else $error("extra cycle on io access");
  trail_mode_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    state_reg == ebwbc_pkg::ST_TRAIL |-> seq_mode) else $error("trailing cycle in fast mode");
  strobe_busy_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    !MEM_STROBE_N |-> ACC_BUSY) else $error("strobe low outside an access");
  addr_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    !MEM_STROBE_N && !$past(MEM_STROBE_N) |-> $stable(EXT_ADDR))
    else $error("address moved under strobe");

  // divided clock, intack and keepers
  div_period_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(DIV_CLK_OUT) && per_ok_reg && $stable(div_fct) && $past(div_fct) != 2'h0 &&
    clk_per_reg != 3'h0
    |-> clk_per_reg == 3'($past(div_fct)) + 3'h1) else $error("divided clock period wrong");
  intack_off_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    bank_ctrl_reg[ebwbc_pkg::ACK_OFF_BIT] |=> INTACK_OUT_N)
    else $error("intack not suppressed");
  addr_keep_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    ADDR_KEEP_EN |-> HOST_KEEP_EN) else $error("address keeper without host keeper");
  data_keep_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    DATA_KEEP_EN == $past(bank_ctrl_reg[ebwbc_pkg::DATA_KEEP_BIT]))
    else $error("data keeper enable wrong");
  host_keep_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    HOST_KEEP_EN == $past(sel_s2_reg | host_keep))
    else $error("host keeper enable wrong");

  seq_cov: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
    state_reg == ebwbc_pkg::ST_TRAIL ##1 state_reg == ebwbc_pkg::ST_DONE);
  switch_cov: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
    take && !seq_mode && switch_hit);
  mult_cov: cover property (@(posedge SYS_CLK) disable iff (!rst_n) take && mult);
  keep_cov: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
    ADDR_KEEP_EN);
  div3_cov: cover property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(DIV_CLK_OUT) && div_fct == 2'h2);
endmodule // ebwbc_top

// [tb/ebwbc_mem_model.sv]
/*
  External memory on the parallel bus: measures each strobe-low phase.
  Assumes strobe and address change just after the rising clock edge.
*/
`timescale 1ns/1ps
module ebwbc_mem_model (
  input wire logic clk, // machine clock
  input wire logic strobe_n, // memory strobe, low active
  input wire logic [22:0] addr, // external address bus
  output int low_count, // cycles of the last strobe phase
  output logic [22:0] last_addr, // address taken at strobe start
  output logic addr_moved // address changed under the strobe
);
  logic strobe_n_reg = 1'b1;
  initial begin
    low_count = 0;
    last_addr = '0;
    addr_moved = 1'b0;
  end
  always @(posedge clk) begin
    strobe_n_reg <= strobe_n;
    if (strobe_n === 1'b0 && strobe_n_reg === 1'b1) begin
      low_count <= 1;
      last_addr <= addr;
    end else if (strobe_n === 1'b0) begin
      low_count <= low_count + 1;
      if (addr !== last_addr) addr_moved <= 1'b1;
    end
  end
endmodule // ebwbc_mem_model

// [tb/ext_bus_wait_bank_control_bench.sv]
/*
  Bench for the external-bus timing block: registers, wait and bank cycles,
  divided clock, intack and keepers. Assumes the memory model beside it.
*/
`timescale 1ns/1ps
module ext_bus_wait_bank_control_bench;
  logic clk, arst_n, we, re, req, rd_n, ireq, wsel;
  logic [15:0] maddr, wdata, rdata;
  logic [1:0] space;
  logic [22:0] aaddr, xaddr, maddr_seen;
  logic done, busy, strb_n, dclk, ack_n, dkeep, akeep, hkeep, moved;
  int bad_count = 0;
  int total_checks = 0;
  int low_count;
  ebwbc_top u_dut (.SYS_CLK(clk), .ARST_N(arst_n), .MMR_ADDR(maddr), .MMR_WDATA(wdata),
    .MMR_WE(we), .MMR_RE(re), .MMR_RDATA(rdata), .ACC_REQ(req), .ACC_READ(rd_n),
    .ACC_SPACE(space), .ACC_ADDR(aaddr), .ACC_DONE(done), .ACC_BUSY(busy),
    .EXT_ADDR(xaddr), .MEM_STROBE_N(strb_n), .DIV_CLK_OUT(dclk), .INTACK_REQ(ireq),
    .INTACK_OUT_N(ack_n), .WIDE_HOST_SEL(wsel), .DATA_KEEP_EN(dkeep),
    .ADDR_KEEP_EN(akeep), .HOST_KEEP_EN(hkeep));
  ebwbc_mem_model u_mem (.clk(clk), .strobe_n(strb_n), .addr(xaddr),
    .low_count(low_count), .last_addr(maddr_seen), .addr_moved(moved));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    maddr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    maddr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk(23'(rdata), 23'(exp), "register read");
  endtask
  // one read; counts strobe-high cycles before the strobe phase
  task automatic access(input logic [1:0] sp, input logic [22:0] a, input int st, input int lw);
    int start = 0;
    int n = 0;
    bit seen = 0;
    space = sp;
    aaddr = a;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk(23'(busy), 23'(1), "busy after take");
    while (done !== 1'b1 && n < 200) begin
      if (strb_n === 1'b0) seen = 1;
      else if (!seen) start++;
      n++;
      @(negedge clk);
    end
    if (n >= 200) begin
      chk(23'(n), 23'(0), "access never finished");
      close_out();
    end
    chk(23'(start), 23'(st), "start cycles");
    chk(23'(low_count), 23'(lw), "strobe cycles");
    chk(maddr_seen, a, "address at memory");
    @(negedge clk);
    chk(23'(busy), 23'(0), "busy after done");
  endtask
  task automatic t_regs();
    rd(16'h0028, 16'h7FFF);
    rd(16'h0029, 16'hF000);
    rd(16'h002B, 16'h0000);
    wr(16'h002B, 16'hFFFF);
    rd(16'h002B, 16'h0001);
    wr(16'h0029, 16'h0FFF);
    rd(16'h0029, 16'h0006);
    rd(16'h002A, 16'h0000);
    wr(16'h0029, 16'hF000);
    wr(16'h002B, 16'h0000);
    access(2'h1, 23'h000010, 4, 8);
  endtask
  task automatic t_mult();
    logic [2:0] base [3] = '{3'h3, 3'h7, 3'h0};
    for (int i = 0; i < 3; i++) begin
      wr(16'h0028, {7'h00, base[i], 6'h00});
      wr(16'h002B, 16'(i > 0));
      access(2'h1, 23'h000010, 4, (32'(base[i]) << (i > 0)) + 1);
    end
  endtask
  task automatic t_banks();
    logic [1:0] sp [10] = '{1, 1, 1, 0, 1, 0, 0, 0, 2, 1};
    logic [22:0] ad [10] = '{23'h10, 23'h20, 23'h8000, 23'h8000, 23'h8000, 23'h8000,
      23'h18000, 23'h18010, 23'h0, 23'h8000};
    int st [10] = '{0, 0, 2, 2, 2, 2, 2, 0, 0, 2};
    wr(16'h0028, 16'h0000);
    wr(16'h002B, 16'h0000);
    wr(16'h0029, 16'h3000);
    for (int i = 0; i < 10; i++) begin
      access(sp[i], ad[i], st[i], 1);
    end
  endtask
  task automatic t_div();
    int n;
    for (int c = 1; c < 4; c++) begin
      wr(16'h0029, 16'h1000 | 16'(c << 13));
      n = 0;
      while (!(dclk === 1'b0) && n < 20) begin n++; @(negedge clk); end
      while (!(dclk === 1'b1) && n < 20) begin n++; @(negedge clk); end
      n = 0;
      do begin n++; @(negedge clk); end while (!(dclk === 1'b1 && n > 1) && n < 20);
      chk(23'(n), 23'(c + 1), "divided clock period");
    end
  endtask
  task automatic t_intack();
    ireq = 1'b1;
    wr(16'h0029, 16'h1000);
    repeat (3) @(negedge clk);
    chk(23'(ack_n), 23'(1), "intack while off");
    wr(16'h0029, 16'h0000);
    repeat (3) @(negedge clk);
    chk(23'(ack_n), 23'(0), "intack while on");
    ireq = 1'b0;
  endtask
  task automatic t_keep();
    for (int i = 0; i < 8; i++) begin
      wr(16'h0029, 16'({i[1:0], 1'b0}));
      wsel = i[2];
      repeat (5) @(negedge clk);
      chk(23'(dkeep), 23'(i[0]), "data keeper");
      chk(23'(akeep), 23'(i[2] & i[1]), "address keeper");
      chk(23'(hkeep), 23'(i[2] | i[1]), "host keeper");
    end
  endtask
  initial begin
    {arst_n, we, re, req, ireq, wsel, maddr, wdata, space, aaddr} = '0;
    rd_n = 1'b1;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_mult();
    t_banks();
    t_div();
    t_intack();
    t_keep();
    chk(23'(moved), 23'(0), "address moved under strobe");
    close_out();
  end
endmodule // ext_bus_wait_bank_control_bench
